// ---- hw/lsu_params.svh ----
`ifndef LSU_PARAMS_SVH
`define LSU_PARAMS_SVH

// architectural register numbers
`define LSU_REG_SP        4'hD
`define LSU_REG_PC        4'hF

// address step of one word and field limits
`define LSU_WORD_STEP     32'h0000_0004
`define LSU_UNPRIV_MAX    13'h00FF
`define LSU_PCREL_MAX     13'h0FFF
`define LSU_PCREL2_MAX    13'h03FC
`define LSU_WORD_ALIGN    2'h0

// flag and list widths
`define LSU_FLAGS_W       4
`define LSU_REGS          16

`endif

// ---- hw/lsu_pkg.sv ----
package lsu_pkg;

  typedef enum logic [2:0] {
    LSU_OP_UNPRIV_LOAD   = 3'h0,
    LSU_OP_UNPRIV_STORE  = 3'h1,
    LSU_OP_PCREL_LOAD    = 3'h2,
    LSU_OP_LOAD_TWO      = 3'h3,
    LSU_OP_LOAD_MULTIPLE = 3'h4,
    LSU_OP_STORE_MULTIPLE = 3'h5
  } lsu_op_t;

  typedef enum logic [1:0] {
    LSU_SIZE_BYTE = 2'h0,
    LSU_SIZE_HALF = 2'h1,
    LSU_SIZE_WORD = 2'h2
  } lsu_size_t;

  // one decoded instruction handed to the unit
  typedef struct packed {
    lsu_op_t           op;
    lsu_size_t         size;
    logic              is_signed;
    logic              decrement_before;
    logic              writeback;
    logic [3:0]        data_register;
    logic [3:0]        second_data_register;
    logic [3:0]        base_register;
    logic [31:0]       base_value;
    logic [31:0]       program_counter;
    logic signed [12:0] offset;
    logic [15:0]       reg_list;
  } lsu_cmd_t;

  // one data bus access
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        write;
    lsu_size_t   size;
    logic        user;
  } lsu_bus_t;

  // one register file write
  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic [31:0] data;
  } lsu_rf_wr_t;

  typedef enum logic [3:0] {
    LSU_ST_IDLE = 4'b0001,
    LSU_ST_READ = 4'b0010,
    LSU_ST_BUS  = 4'b0100,
    LSU_ST_FIN  = 4'b1000
  } lsu_state_t;

endpackage

// ---- hw/lsu_unit.sv ----
// Contract
// - unprivileged access address is base plus unsigned offset 0 to 255.
// - unprivileged accesses always go out with unprivileged permission.
// - from unprivileged software they act like ordinary immediate-offset accesses.
// - byte and halfword loads zero- or sign-extend to 32 bits; signed only loads.
// - pc-relative address is pc plus signed offset, 4095 single, 1020 two-word.
// - two-word load fills two distinct registers; second is not sp or pc.
// - only word pc-relative load and load multiple target sp or pc; pc load needs bit0, branches cleared.
// - unprivileged base not pc; data register not sp or pc; else rejected.
// - no form here changes the condition flags.
// - multiple transfers default increment-after, first at base, then higher words.
// - decrement-before accesses occupy the words below the base.
// - with writeback the final address is written into the base register.
// - a multiple transfer needs at least one register in its list.
// - multiple transfers use 4-byte steps, lowest register at lowest address.
`include "lsu_params.svh"

module lsu_unit (
  // clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  // command
  input  wire logic                        cmd_valid_in,
  input  wire lsu_pkg::lsu_cmd_t           cmd_in,
  input  wire logic                        privileged_in,
  input  wire logic [`LSU_FLAGS_W-1:0]     flags_in,
  output logic                             cmd_ready_out,
  output logic                             done_out,
  output logic                             error_out,
  output logic [`LSU_FLAGS_W-1:0]          flags_out,
  // register file
  output logic [3:0]                       rf_rd_idx_out,
  input  wire logic [31:0]                 rf_rd_data_in,
  output lsu_pkg::lsu_rf_wr_t              rf_wr_out,
  // branch
  output logic                             branch_valid_out,
  output logic [31:0]                      branch_addr_out,
  // data bus
  output logic                             bus_req_out,
  output lsu_pkg::lsu_bus_t                bus_out,
  input  wire logic                        bus_ack_in,
  input  wire logic [31:0]                 bus_rdata_in
);
  import lsu_pkg::*;

  function automatic logic [4:0] lsu_count(input logic [15:0] list);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < `LSU_REGS; i++) begin
      n = n + {4'h0, list[i]};
    end
    return n;
  endfunction

  function automatic logic [3:0] lsu_lowest(input logic [15:0] list);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = `LSU_REGS - 1; i >= 0; i--) begin
      if (list[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // state
  lsu_state_t          state_q, state_d;
  lsu_cmd_t            cmd_q;
  logic                user_q;
  logic [31:0]         addr_q;
  logic [31:0]         wb_value_q;
  logic [15:0]         mask_q;
  logic [3:0]          cur_idx_q;
  logic                second_q;
  logic                pc_pending_q;
  logic [31:0]         pc_value_q;
  logic [31:0]         wdata_q;
  logic                cmd_ready_q, done_q, error_q, branch_valid_q, bus_req_q;
  logic [31:0]         branch_addr_q;
  logic [3:0]          rf_rd_idx_q;
  lsu_rf_wr_t          rf_wr_q;
  lsu_bus_t            bus_q;
  logic [`LSU_FLAGS_W-1:0] flags_q;

  // decode of the incoming command
  wire logic         is_unpriv  = (cmd_in.op == LSU_OP_UNPRIV_LOAD) ||
                                  (cmd_in.op == LSU_OP_UNPRIV_STORE);
  wire logic         is_pcrel   = (cmd_in.op == LSU_OP_PCREL_LOAD);
  wire logic         is_two     = (cmd_in.op == LSU_OP_LOAD_TWO);
  wire logic         is_multi   = (cmd_in.op == LSU_OP_LOAD_MULTIPLE) ||
                                  (cmd_in.op == LSU_OP_STORE_MULTIPLE);
  wire logic         dr_sp_pc   = (cmd_in.data_register == `LSU_REG_SP) ||
                                  (cmd_in.data_register == `LSU_REG_PC);
  wire logic         dr2_sp_pc  = (cmd_in.second_data_register == `LSU_REG_SP) ||
                                  (cmd_in.second_data_register == `LSU_REG_PC);
  wire logic [12:0]  off_mag    = cmd_in.offset[12] ? 13'(-cmd_in.offset) : cmd_in.offset;
  wire logic         bad_unpriv = is_unpriv &&
                                  (cmd_in.offset[12] || (cmd_in.offset > `LSU_UNPRIV_MAX) ||
                                   (cmd_in.base_register == `LSU_REG_PC) || dr_sp_pc ||
                                   (cmd_in.op == LSU_OP_UNPRIV_STORE && cmd_in.is_signed) ||
                                   (cmd_in.size == LSU_SIZE_WORD && cmd_in.is_signed));
  wire logic         bad_pcrel  = is_pcrel &&
                                  ((off_mag > `LSU_PCREL_MAX) ||
                                   (dr_sp_pc && cmd_in.size != LSU_SIZE_WORD));
  wire logic         bad_two    = is_two &&
                                  ((off_mag > `LSU_PCREL2_MAX) ||
                                   (off_mag[1:0] != `LSU_WORD_ALIGN) || dr2_sp_pc || dr_sp_pc ||
                                   (cmd_in.data_register == cmd_in.second_data_register));
  wire logic         bad_multi  = is_multi && (cmd_in.reg_list == 16'h0000);
  wire logic         cmd_bad    = bad_unpriv || bad_pcrel || bad_two || bad_multi;
  wire logic         cmd_take   = cmd_valid_in && (state_q == LSU_ST_IDLE);

  wire logic [31:0]  off_ext    = {{19{cmd_in.offset[12]}}, cmd_in.offset};
  wire logic [31:0]  list_bytes = {25'h0000000, lsu_count(cmd_in.reg_list), 2'h0};
  wire logic [31:0]  start_addr = is_unpriv ? cmd_in.base_value + off_ext :
                                  is_multi  ? (cmd_in.decrement_before ?
                                               cmd_in.base_value - list_bytes :
                                               cmd_in.base_value) :
                                  cmd_in.program_counter + off_ext;
  wire logic [31:0]  final_addr = cmd_in.decrement_before ?
                                  cmd_in.base_value - list_bytes :
                                  cmd_in.base_value + list_bytes;
  wire logic [3:0]   first_idx  = is_multi ? lsu_lowest(cmd_in.reg_list) :
                                  cmd_in.data_register;

  // progress of the running transfer
  wire logic         cur_load   = (cmd_q.op != LSU_OP_UNPRIV_STORE) &&
                                  (cmd_q.op != LSU_OP_STORE_MULTIPLE);
  wire logic [15:0]  mask_rest  = mask_q & ~(16'h0001 << cur_idx_q);
  wire logic         more_multi = (cmd_q.op == LSU_OP_LOAD_MULTIPLE ||
                                   cmd_q.op == LSU_OP_STORE_MULTIPLE) && (mask_rest != 16'h0000);
  wire logic         more_two   = (cmd_q.op == LSU_OP_LOAD_TWO) && !second_q;
  wire logic         more       = more_multi || more_two;
  wire logic [3:0]   next_idx   = more_two ? cmd_q.second_data_register : lsu_lowest(mask_rest);
  wire logic         bus_done   = (state_q == LSU_ST_BUS) && bus_ack_in;

  // load data extension
  wire logic [31:0]  ld_byte    = {{24{cmd_q.is_signed & bus_rdata_in[7]}}, bus_rdata_in[7:0]};
  wire logic [31:0]  ld_half    = {{16{cmd_q.is_signed & bus_rdata_in[15]}}, bus_rdata_in[15:0]};
  wire logic [31:0]  ld_data    = (bus_q.size == LSU_SIZE_BYTE) ? ld_byte :
                                  (bus_q.size == LSU_SIZE_HALF) ? ld_half : bus_rdata_in;
  wire logic         ld_to_pc   = cur_load && (cur_idx_q == `LSU_REG_PC);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LSU_ST_IDLE: begin
        if (cmd_valid_in && !cmd_bad) begin
          state_d = LSU_ST_READ;
        end
      end
      LSU_ST_READ: begin
        state_d = LSU_ST_BUS;
      end
      LSU_ST_BUS: begin
        if (bus_ack_in) begin
          state_d = more ? LSU_ST_READ : LSU_ST_FIN;
        end
      end
      LSU_ST_FIN: begin
        state_d = LSU_ST_IDLE;
      end
      default: begin
        state_d = LSU_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= LSU_ST_IDLE;
      cmd_q   <= '0;
      user_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cmd_take) begin
        cmd_q  <= cmd_in;
        user_q <= is_unpriv || !privileged_in;
      end
    end
  end

  // address walk
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q     <= 32'h0000_0000;
      wb_value_q <= 32'h0000_0000;
      mask_q     <= 16'h0000;
      cur_idx_q  <= 4'h0;
      second_q   <= 1'b0;
    end else if (cmd_take) begin
      addr_q     <= start_addr;
      wb_value_q <= final_addr;
      mask_q     <= cmd_in.reg_list;
      cur_idx_q  <= first_idx;
      second_q   <= 1'b0;
    end else if (bus_done && more) begin
      addr_q    <= addr_q + `LSU_WORD_STEP;
      mask_q    <= mask_rest;
      cur_idx_q <= next_idx;
      second_q  <= 1'b1;
    end
  end

  // register read then bus access
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rf_rd_idx_q <= 4'h0;
      bus_req_q   <= 1'b0;
      bus_q       <= '0;
    end else begin
      rf_rd_idx_q <= (state_d == LSU_ST_READ) ? (cmd_take ? first_idx : next_idx) : rf_rd_idx_q;
      if (state_q == LSU_ST_READ) begin
        bus_req_q   <= 1'b1;
        bus_q.addr  <= addr_q;
        bus_q.wdata <= cur_load ? 32'h0000_0000 : rf_rd_data_in;
        bus_q.write <= !cur_load;
        bus_q.size  <= (cmd_q.op == LSU_OP_UNPRIV_LOAD || cmd_q.op == LSU_OP_UNPRIV_STORE ||
                        cmd_q.op == LSU_OP_PCREL_LOAD) ? cmd_q.size : LSU_SIZE_WORD;
        bus_q.user  <= user_q;
      end else if (bus_done) begin
        bus_req_q <= 1'b0;
      end
    end
  end

  // results: register writes, branch, completion
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rf_wr_q        <= '0;
      pc_pending_q   <= 1'b0;
      pc_value_q     <= 32'h0000_0000;
      branch_valid_q <= 1'b0;
      branch_addr_q  <= 32'h0000_0000;
      done_q         <= 1'b0;
      error_q        <= 1'b0;
      cmd_ready_q    <= 1'b0;
      flags_q        <= '0;
    end else begin
      rf_wr_q        <= '0;
      branch_valid_q <= 1'b0;
      done_q         <= 1'b0;
      error_q        <= cmd_valid_in && (state_q == LSU_ST_IDLE) && cmd_bad;
      cmd_ready_q    <= (state_d == LSU_ST_IDLE);
      flags_q        <= (state_q == LSU_ST_IDLE) ? flags_in : flags_q;
      if (cmd_take) begin
        pc_pending_q <= 1'b0;
      end
      if (bus_done && cur_load) begin
        if (ld_to_pc) begin
          pc_pending_q <= 1'b1;
          pc_value_q   <= ld_data;
        end else begin
          rf_wr_q.en   <= 1'b1;
          rf_wr_q.idx  <= cur_idx_q;
          rf_wr_q.data <= ld_data;
        end
      end
      if (state_q == LSU_ST_FIN) begin
        done_q <= 1'b1;
        if (cmd_q.writeback && (cmd_q.op == LSU_OP_LOAD_MULTIPLE ||
                                cmd_q.op == LSU_OP_STORE_MULTIPLE)) begin
          rf_wr_q.en   <= 1'b1;
          rf_wr_q.idx  <= cmd_q.base_register;
          rf_wr_q.data <= wb_value_q;
        end
        if (pc_pending_q) begin
          branch_valid_q <= pc_value_q[0];
          branch_addr_q  <= {pc_value_q[31:1], 1'b0};
          error_q        <= !pc_value_q[0];
        end
      end
    end
  end

  assign cmd_ready_out    = cmd_ready_q;
  assign done_out         = done_q;
  assign error_out        = error_q;
  assign flags_out        = flags_q;
  assign rf_rd_idx_out    = rf_rd_idx_q;
  assign rf_wr_out        = rf_wr_q;
  assign branch_valid_out = branch_valid_q;
  assign branch_addr_out  = branch_addr_q;
  assign bus_req_out      = bus_req_q;
  assign bus_out          = bus_q;

endmodule // lsu_unit

// ---- dv/lsu_mem_model.sv ----
module lsu_mem_model (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  // stall cycles before the next answer
  input  wire logic [1:0]        lat_in,
  // data bus seen from memory
  input  wire logic              req_in,
  input  wire lsu_pkg::lsu_bus_t bus_in,
  output logic                   ack_out,
  output logic [31:0]            rdata_out
);
  import lsu_pkg::*;
  logic [1:0] wait_q;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_out <= 1'b0;
      rdata_out <= 32'h0;
      wait_q <= 2'h0;
    end else if (req_in && !ack_out && wait_q == 2'h0) begin
      ack_out <= 1'b1;
      rdata_out <= bus_in.addr ^ 32'h8080_8080;
      wait_q <= lat_in;
    end else begin
      // read data is only good in the ack cycle
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (req_in && wait_q != 2'h0) wait_q <= wait_q - 2'h1;
    end
  end
endmodule // lsu_mem_model

// ---- dv/lsu_monitor.sv ----
`include "lsu_params.svh"
module lsu_monitor (
  // clock and reset
  input wire logic              clk_in,
  input wire logic              resetn_in,
  // command side
  input wire logic              cmd_valid_in,
  input wire lsu_pkg::lsu_cmd_t cmd_in,
  input wire logic [3:0]        flags_in,
  input wire logic              cmd_ready_out,
  input wire logic              done_out,
  input wire logic              error_out,
  input wire logic [3:0]        flags_out,
  input wire logic              branch_valid_out,
  input wire logic [31:0]       branch_addr_out,
  // data bus
  input wire logic              bus_req_out,
  input wire lsu_pkg::lsu_bus_t bus_out,
  input wire logic              bus_ack_in
);
  import lsu_pkg::*;
  lsu_cmd_t    cmd_q;
  logic [31:0] prev_q;
  logic        seen_q;
  wire unp_w = cmd_q.op inside {LSU_OP_UNPRIV_LOAD, LSU_OP_UNPRIV_STORE};
  wire mul_w = cmd_q.op inside {LSU_OP_LOAD_MULTIPLE, LSU_OP_STORE_MULTIPLE};
  wire seq_w = mul_w || cmd_q.op == LSU_OP_LOAD_TWO;
  wire empty_w = cmd_in.op inside {LSU_OP_LOAD_MULTIPLE, LSU_OP_STORE_MULTIPLE}
                 && cmd_in.reg_list == 16'h0;
  wire badreg_w = cmd_in.op inside {LSU_OP_UNPRIV_LOAD, LSU_OP_UNPRIV_STORE}
                  && (cmd_in.base_register == `LSU_REG_PC
                  || cmd_in.data_register inside {`LSU_REG_SP, `LSU_REG_PC});
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_q <= '0;
      prev_q <= 32'h0;
      seen_q <= 1'b0;
    end else if (cmd_valid_in && cmd_ready_out) begin
      cmd_q <= cmd_in;
      seen_q <= 1'b0;
    end else if (bus_req_out && bus_ack_in) begin
      prev_q <= bus_out.addr;
      seen_q <= 1'b1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_take; cmd_valid_in && cmd_ready_out; endsequence
  sequence s_refused; ##[0:1] (error_out && !bus_req_out); endsequence
  property p_unpriv_addr;
    $rose(bus_req_out) && unp_w |-> bus_out.addr == cmd_q.base_value + 32'(cmd_q.offset);
  endproperty
  a_unpriv_addr: assert property (p_unpriv_addr)
    else $error("unprivileged address wrong");
  property p_unpriv_user; bus_req_out && unp_w |-> bus_out.user; endproperty
  a_unpriv_user: assert property (p_unpriv_user)
    else $error("unprivileged access not marked user");
  property p_pcrel_addr;
    $rose(bus_req_out) && !seen_q && cmd_q.op inside {LSU_OP_PCREL_LOAD, LSU_OP_LOAD_TWO}
      |-> bus_out.addr == cmd_q.program_counter + 32'(cmd_q.offset);
  endproperty
  a_pcrel_addr: assert property (p_pcrel_addr)
    else $error("pc relative address wrong");
  property p_step; $rose(bus_req_out) && seen_q && seq_w |-> bus_out.addr == prev_q + 32'h4;
  endproperty
  a_step: assert property (p_step)
    else $error("next access not one word higher");
  property p_ia_first;
    $rose(bus_req_out) && !seen_q && mul_w && !cmd_q.decrement_before
      |-> bus_out.addr == cmd_q.base_value;
  endproperty
  a_ia_first: assert property (p_ia_first)
    else $error("increment after does not start at base");
  property p_branch; branch_valid_out |-> done_out && !branch_addr_out[0]; endproperty
  a_branch: assert property (p_branch)
    else $error("branch without done or with bit0 set");
  property p_flags; done_out |-> flags_out == $past(flags_out, 2); endproperty
  a_flags: assert property (p_flags)
    else $error("flags changed during transfer");
  property p_empty; s_take ##0 empty_w |=> s_refused; endproperty
  a_empty: assert property (p_empty)
    else $error("empty list not refused");
  property p_badreg; s_take ##0 badreg_w |=> s_refused; endproperty
  a_badreg: assert property (p_badreg)
    else $error("bad unprivileged register not refused");
endmodule // lsu_monitor

bind lsu_unit lsu_monitor u_mon (.clk_in(clk_in), .resetn_in(resetn_in),
  .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .flags_in(flags_in),
  .cmd_ready_out(cmd_ready_out), .done_out(done_out), .error_out(error_out),
  .flags_out(flags_out), .branch_valid_out(branch_valid_out),
  .branch_addr_out(branch_addr_out), .bus_req_out(bus_req_out), .bus_out(bus_out),
  .bus_ack_in(bus_ack_in));

// ---- dv/tb.sv ----
`include "lsu_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import lsu_pkg::*;
  logic clk_in = 1'b0, resetn_in = 1'b0, cmd_valid_in = 1'b0, privileged_in = 1'b0;
  logic cmd_ready_out, done_out, error_out, branch_valid_out, bus_req_out, bus_ack_in;
  logic [3:0] flags_in = 4'h0, flags_out, rf_rd_idx_out, xf[$];
  logic [31:0] branch_addr_out, bus_rdata_in, rf_rd_data_in, xbr[$];
  logic [1:0] lat = 2'h0;
  lsu_cmd_t cmd_in = '0;
  lsu_bus_t bus_out, xb[$];
  lsu_rf_wr_t rf_wr_out, xw[$];
  logic [1:0] xe[$];
  int errors = 0, checks = 0;
  always #50 clk_in = ~clk_in;
  function automatic logic [31:0] rv(logic [3:0] i);
    return {i, 4'hA, i, 4'h5, i, 4'h3, i, 4'hC};
  endfunction
  function automatic logic [31:0] md(logic [31:0] a);
    return a ^ 32'h8080_8080;
  endfunction
  function automatic logic [31:0] ext(logic [31:0] d, lsu_size_t s, logic sg);
    if (s == LSU_SIZE_BYTE) return sg ? {{24{d[7]}}, d[7:0]} : {24'h0, d[7:0]};
    if (s == LSU_SIZE_HALF) return sg ? {{16{d[15]}}, d[15:0]} : {16'h0, d[15:0]};
    return d;
  endfunction
  function automatic lsu_bus_t mk(lsu_bus_t b);
    if (!(b.write && b.size == LSU_SIZE_WORD)) b.wdata = 32'h0;
    return b;
  endfunction
  assign rf_rd_data_in = rv(rf_rd_idx_out);
  lsu_unit u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .privileged_in(privileged_in), .flags_in(flags_in),
    .cmd_ready_out(cmd_ready_out), .done_out(done_out), .error_out(error_out),
    .flags_out(flags_out), .rf_rd_idx_out(rf_rd_idx_out), .rf_rd_data_in(rf_rd_data_in),
    .rf_wr_out(rf_wr_out), .branch_valid_out(branch_valid_out),
    .branch_addr_out(branch_addr_out), .bus_req_out(bus_req_out), .bus_out(bus_out),
    .bus_ack_in(bus_ack_in), .bus_rdata_in(bus_rdata_in));
  lsu_mem_model u_mem (.clk_in(clk_in), .resetn_in(resetn_in), .lat_in(lat),
    .req_in(bus_req_out), .bus_in(bus_out), .ack_out(bus_ack_in), .rdata_out(bus_rdata_in));
  task automatic chk(string n, logic [67:0] s, logic [67:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(negedge clk_in) begin
    flags_in <= 4'($urandom);
    lat <= 2'($urandom);
  end
  always @(posedge clk_in) begin
    if (bus_req_out && bus_ack_in) chk("bus", mk(bus_out), mk(xb.pop_front()));
    if (rf_wr_out.en && rf_wr_out.idx != `LSU_REG_PC) chk("rf", rf_wr_out, xw.pop_front());
    if (done_out || error_out) chk("end", {done_out, error_out}, xe.pop_front());
    if (done_out || error_out) chk("flags", flags_out, xf.pop_front());
    if (branch_valid_out) chk("branch", branch_addr_out, xbr.pop_front());
  end
  task automatic run(lsu_cmd_t c, logic priv);
    int n;
    @(negedge clk_in);
    cmd_in = c;
    privileged_in = priv;
    cmd_valid_in = 1'b1;
    n = 0;
    do begin @(posedge clk_in); n++; end while (!cmd_ready_out && n < 50);
    if (n >= 50) chk("ready", 1, 0);
    // flags seen at the take edge must come back unchanged at the end
    xf.push_back(flags_in);
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    n = 0;
    do begin @(posedge clk_in); n++; end while (!(done_out || error_out) && n < 200);
    if (n >= 200) chk("finish", 1, 0);
  endtask
  task automatic go(lsu_cmd_t c, logic priv);
    logic [31:0] a;
    logic [31:0] n4;
    logic u;
    u = c.op inside {LSU_OP_UNPRIV_LOAD, LSU_OP_UNPRIV_STORE} || !priv;
    n4 = 32'($countones(c.reg_list)) * 32'h4;
    a = c.op inside {LSU_OP_PCREL_LOAD, LSU_OP_LOAD_TWO} ? c.program_counter : c.base_value;
    if (c.op < LSU_OP_LOAD_MULTIPLE) a = a + 32'(c.offset);
    else if (c.decrement_before) a = a - n4;
    if (c.op == LSU_OP_UNPRIV_STORE) xb.push_back('{a, rv(c.data_register), 1'b1, c.size, u});
    else if (c.op < LSU_OP_LOAD_MULTIPLE) begin
      xb.push_back('{a, 32'h0, 1'b0, c.size, u});
      if (c.data_register != `LSU_REG_PC)
        xw.push_back('{1'b1, c.data_register, ext(md(a), c.size, c.is_signed)});
      if (c.data_register == `LSU_REG_PC && a[0]) xbr.push_back(md(a) & ~32'h1);
      if (c.op == LSU_OP_LOAD_TWO) begin
        xb.push_back('{a + 32'h4, 32'h0, 1'b0, LSU_SIZE_WORD, u});
        xw.push_back('{1'b1, c.second_data_register, md(a + 32'h4)});
      end
    end else for (int i = 0; i < 16; i++) if (c.reg_list[i]) begin
      xb.push_back('{a, rv(4'(i)), c.op == LSU_OP_STORE_MULTIPLE, LSU_SIZE_WORD, u});
      if (c.op == LSU_OP_LOAD_MULTIPLE) xw.push_back('{1'b1, 4'(i), md(a)});
      a = a + 32'h4;
    end
    if (c.writeback && c.op > LSU_OP_LOAD_TWO) xw.push_back('{1'b1, c.base_register,
      c.decrement_before ? c.base_value - n4 : c.base_value + n4});
    xe.push_back(c.data_register == `LSU_REG_PC && !a[0] && c.op == LSU_OP_PCREL_LOAD ? 2'h3 : 2'h2);
    run(c, priv);
  endtask
  initial begin
    lsu_cmd_t c;
    void'($urandom(32'hd179));
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    for (int k = 0; k < 5; k++) begin
      c = '0;
      c.op = LSU_OP_UNPRIV_LOAD;
      c.size = lsu_size_t'(k / 2);
      c.is_signed = k[0] && k < 4;
      c.data_register = 4'(k + 1);
      c.base_value = $urandom;
      c.offset = k[0] ? 13'sh00FF : 13'sh0000;
      go(c, 1'b1);
    end
    c.op = LSU_OP_UNPRIV_STORE;
    go(c, 1'b0);
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.op = LSU_OP_PCREL_LOAD;
      c.size = k < 2 ? LSU_SIZE_HALF : LSU_SIZE_WORD;
      c.is_signed = k < 2;
      c.data_register = k < 2 ? 4'h6 : `LSU_REG_PC;
      c.program_counter = $urandom;
      c.program_counter[0] = k[0];
      c.offset = k[0] ? 13'sh0FFF : -13'sh0FFF;
      go(c, 1'b0);
    end
    c.op = LSU_OP_LOAD_TWO;
    c.data_register = 4'h4;
    c.second_data_register = 4'h5;
    c.offset = -13'sh03FC;
    go(c, 1'b1);
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.op = k[0] ? LSU_OP_STORE_MULTIPLE : LSU_OP_LOAD_MULTIPLE;
      c.decrement_before = k[1];
      c.writeback = k != 2;
      c.base_register = 4'hC;
      c.base_value = $urandom & 32'hFFFF_FFFC;
      c.reg_list = k == 2 ? 16'h0800 : 16'($urandom) & 16'h0FFF | 16'h0001;
      go(c, k[0]);
    end
    for (int k = 0; k < 9; k++) begin
      c = '0;
      c.op = k inside {4, 5, 8} ? LSU_OP_LOAD_TWO : k == 6 ? LSU_OP_LOAD_MULTIPLE
           : k == 7 ? LSU_OP_PCREL_LOAD : LSU_OP_UNPRIV_LOAD;
      c.size = LSU_SIZE_WORD;
      c.data_register = k == 2 ? `LSU_REG_SP : k == 8 ? `LSU_REG_PC : 4'h1;
      c.second_data_register = k == 5 ? `LSU_REG_SP : 4'(k == 4);
      c.base_register = k == 1 ? `LSU_REG_PC : 4'h2;
      c.is_signed = k == 3;
      c.offset = k == 0 ? 13'sh0100 : k == 7 ? 13'sh1000 : 13'sh0000;
      xe.push_back(2'h1);
      run(c, 1'b0);
    end
    repeat (5) @(posedge clk_in);
    chk("left", xb.size() + xw.size() + xe.size() + xf.size() + xbr.size(), 0);
    end_sim();
  end
  initial begin
    #(5000 * 100);
    errors++;
    end_sim();
  end
endmodule // tb
